// file: hdl/psr_pkg.sv
/*
 * Shared constants and carrier types for the parallel-in, serial-out
 * shift register with input storage.
 * Assumes a single 50 MHz system clock; all host inputs synchronous to it.
 */
package psr_pkg;

    // ----------------------------------------------------------------
    // widths and reset values
    // ----------------------------------------------------------------
    localparam int           PSR_WIDTH      = 8;
    localparam int           PSR_FIFO_DEPTH = 4;
    localparam int           PSR_FIFO_WIDTH = 1;
    localparam logic [7:0]   PSR_STORE_RST  = 8'h00;
    localparam logic [7:0]   PSR_SHIFT_RST  = 8'h00;
    localparam logic [7:0]   PSR_CLEARED    = 8'h00;
    localparam logic         PSR_CLK_RST    = 1'b0;

    // ----------------------------------------------------------------
    // host control carrier
    // ----------------------------------------------------------------
    typedef struct packed {
        logic storage_clock;
        logic shift_clock;
        logic parallel_load_n;
        logic shift_clear_n;
        logic serial_in;
    } psr_ctrl_type;

    // action taken on the shift register in one cycle
    typedef enum logic [2:0] {
        PSR_HOLD,
        PSR_CLEAR,
        PSR_LOAD_PINS,
        PSR_LOAD_STORE,
        PSR_SHIFT
    } psr_action_type;

endpackage : psr_pkg

// file: hdl/psr_top.sv
/*
 * Parallel-in, serial-out shift register with an input storage register,
 * plus a small FIFO collecting each bit shifted out of the last stage while it has room.
 * Assumes every input is synchronous to clock_i; storage_clock and
 * shift_clock are sampled levels whose rising edges are detected here.
 */
// Behaviour
// - two 8-bit holders: storage register from pins, loadable/serial shift register.
// - storage updates only on storage_clock edges; shift register on shift_clock edges or on load and clear levels.
// - every storage_clock rising edge captures parallel_in into storage register.
// - storage edge with load low, clear high passes new pins into shift register.
// - load low, clear high copies storage into shift register without clock edge.
// - clear low, load high zeroes shift register; storage register untouched.
// - shift only on shift_clock rising edge while load and clear both high.
// - on shift, stage n takes stage n-1, stage 0 takes serial_in.
`timescale 1ns/1ns

module psr_fifo #(
    parameter int WIDTH = 1,
    parameter int DEPTH = 4
) (
    input  wire logic             clock_i,
    input  wire logic             resetn_i,
    input  wire logic             in_valid_i,
    input  wire logic [WIDTH-1:0] in_data_i,
    output logic                  in_ready_o,
    output logic                  out_valid_o,
    output logic      [WIDTH-1:0] out_data_o,
    input  wire logic             out_ready_i
);
    localparam int CW = $clog2(DEPTH + 1);

    logic [WIDTH-1:0] mem_q [DEPTH];
    logic [CW-1:0]    count_q;
    logic [CW-1:0]    count_d;
    logic             push;
    logic             pop;

    assign push = in_valid_i & in_ready_o;
    assign pop  = out_valid_o & out_ready_i;

    // ----------------------------------------------------------------
    // occupancy and flags
    // ----------------------------------------------------------------
    // flags are registered from the next count so both ports see plain
    // flops; a full buffer therefore refuses a push even when its head
    // leaves in the same cycle

    always_comb begin
        count_d = count_q;
        if (push && !pop) begin
            count_d = CW'(count_q + 1'b1);
        end else if (pop && !push) begin
            count_d = CW'(count_q - 1'b1);
        end
    end

    always_ff @(posedge clock_i or negedge resetn_i) begin
        if (!resetn_i) begin
            count_q     <= '0;
            out_valid_o <= 1'b0;
            in_ready_o  <= 1'b1;
        end else begin
            count_q     <= count_d;
            out_valid_o <= (count_d != '0);
            in_ready_o  <= (count_d != CW'(DEPTH));
        end
    end

    // ----------------------------------------------------------------
    // entries shift toward the head so the output is a plain flop
    // ----------------------------------------------------------------
    genvar gi;
    generate
        for (gi = 0; gi < DEPTH; gi++) begin : g_entry
            // the top entry has nothing above it; a pop loads it with zero unless the input lands there
            logic [WIDTH-1:0] upper;
            if (gi == DEPTH - 1) begin : g_top
                assign upper = '0;
            end else begin : g_mid
                assign upper = mem_q[gi+1];
            end
            always_ff @(posedge clock_i or negedge resetn_i) begin
                if (!resetn_i) begin
                    mem_q[gi] <= '0;
                end else if (pop) begin
                    mem_q[gi] <= (push && CW'(gi + 1) == count_q) ? in_data_i : upper;
                end else if (push && CW'(gi) == count_q) begin
                    mem_q[gi] <= in_data_i;
                end
            end
        end
    endgenerate

    assign out_data_o = mem_q[0];

    default clocking cb @(posedge clock_i); endclocking
    default disable iff (!resetn_i);

    a_fifo_count_bound: assert property (count_q <= CW'(DEPTH))
        else $error("fifo count exceeds depth");
    a_fifo_full_stall: assert property ((count_q == CW'(DEPTH)) |-> !in_ready_o)
        else $error("fifo accepts while full");
    a_fifo_room_ready: assert property ((count_q != CW'(DEPTH)) |-> in_ready_o)
        else $error("fifo refuses while it has room");
    a_fifo_empty_idle: assert property ((count_q == '0) |-> !out_valid_o)
        else $error("fifo offers data while empty");

    a_fifo_push_count: assert property (push && !pop |=> count_q == CW'($past(count_q) + 1'b1))
        else $error("fifo count missed a push");
    a_fifo_pop_count: assert property (pop && !push |=> count_q == CW'($past(count_q) - 1'b1))
        else $error("fifo count missed a pop");
    a_fifo_both_hold: assert property (push && pop |=> $stable(count_q))
        else $error("fifo count moved on push with pop");

    // an empty buffer shows a new word at its head one cycle later
    a_fifo_first_word: assert property (push && (count_q == '0) |=> out_data_o == $past(in_data_i))
        else $error("fifo head missed first word");
    a_fifo_head_hold: assert property (out_valid_o && !pop |=> $stable(out_data_o))
        else $error("fifo head changed without pop");
endmodule // psr_fifo

module psr_top
    import psr_pkg::*;
(
    input  wire logic                 clock_i,
    input  wire logic                 resetn_i,
    input  wire psr_ctrl_type         ctrl_i,
    input  wire logic [PSR_WIDTH-1:0] parallel_in_i,
    output logic                      serial_out_o,
    output logic                      shift_ready_o,
    output logic                      bit_valid_o,
    output logic                      bit_data_o,
    input  wire logic                 bit_ready_i
);
    logic [PSR_WIDTH-1:0] store_q;
    logic [PSR_WIDTH-1:0] shift_q;
    logic                 stor_clk_q;
    logic                 shift_clk_q;
    logic                 stor_edge;
    logic                 shift_edge;
    logic                 load_act;
    logic                 clear_act;
    psr_action_type       action;

    // ----------------------------------------------------------------
    // clock edge detection
    // ----------------------------------------------------------------
    // detectors start low, matching the idle level of both clock pins;
    // a pin already high when reset lifts counts as one rising edge
    always_ff @(posedge clock_i or negedge resetn_i) begin
        if (!resetn_i) begin
            stor_clk_q  <= PSR_CLK_RST;
            shift_clk_q <= PSR_CLK_RST;
        end else begin
            stor_clk_q  <= ctrl_i.storage_clock;
            shift_clk_q <= ctrl_i.shift_clock;
        end
    end

    assign stor_edge  = ctrl_i.storage_clock & ~stor_clk_q;
    assign shift_edge = ctrl_i.shift_clock & ~shift_clk_q;
    assign load_act   = ~ctrl_i.parallel_load_n;
    assign clear_act  = ~ctrl_i.shift_clear_n;

    // ----------------------------------------------------------------
    // storage register
    // ----------------------------------------------------------------
    // clear never reaches here; only the storage clock moves this register
    always_ff @(posedge clock_i or negedge resetn_i) begin
        if (!resetn_i) begin
            store_q <= PSR_STORE_RST;
        end else if (stor_edge) begin
            store_q <= parallel_in_i;
        end
    end

    // ----------------------------------------------------------------
    // shift register action select
    // ----------------------------------------------------------------
    // load and clear together is illegal for the host; clear is given
    // priority so the register at least settles to a known value;
    // a storage edge during load hands the pins straight through, since
    // the stored copy would only catch up one cycle later
    always_comb begin
        if (clear_act) begin
            action = PSR_CLEAR;
        end else if (load_act && stor_edge) begin
            action = PSR_LOAD_PINS;
        end else if (load_act) begin
            action = PSR_LOAD_STORE;
        end else if (shift_edge) begin
            action = PSR_SHIFT;
        end else begin
            action = PSR_HOLD;
        end
    end

    // level-held load and clear act on every edge, one cycle behind the pin
    always_ff @(posedge clock_i or negedge resetn_i) begin
        if (!resetn_i) begin
            shift_q <= PSR_SHIFT_RST;
        end else begin
            case (action)
                PSR_CLEAR:      shift_q <= PSR_CLEARED;
                PSR_LOAD_PINS:  shift_q <= parallel_in_i;
                PSR_LOAD_STORE: shift_q <= store_q;
                PSR_SHIFT:      shift_q <= {shift_q[PSR_WIDTH-2:0], ctrl_i.serial_in};
                default:        shift_q <= shift_q;
            endcase
        end
    end

    assign serial_out_o = shift_q[PSR_WIDTH-1];

    // ----------------------------------------------------------------
    // shifted-out bit buffer
    // ----------------------------------------------------------------
    // a bit offered while the buffer is full is lost; the host must
    // watch shift_ready_o before raising shift_clock
    psr_fifo #(
        .WIDTH (PSR_FIFO_WIDTH),
        .DEPTH (PSR_FIFO_DEPTH)
    ) u_fifo (
        .clock_i     (clock_i),
        .resetn_i    (resetn_i),
        .in_valid_i  (action == PSR_SHIFT),
        .in_data_i   (shift_q[PSR_WIDTH-1]),
        .in_ready_o  (shift_ready_o),
        .out_valid_o (bit_valid_o),
        .out_data_o  (bit_data_o),
        .out_ready_i (bit_ready_i)
    );

    // ----------------------------------------------------------------
    // assertions
    // ----------------------------------------------------------------
    default clocking cb @(posedge clock_i); endclocking
    default disable iff (!resetn_i);

    sequence s_run_mode;
        ctrl_i.parallel_load_n && ctrl_i.shift_clear_n;
    endsequence

    // rising shift_clock seen from the pin itself, not from the detector
    sequence s_shift_req;
        s_run_mode ##0 (ctrl_i.shift_clock && !$past(ctrl_i.shift_clock));
    endsequence

    sequence s_shift_pair;
        s_shift_req ##1 s_run_mode ##1 s_shift_req;
    endsequence

    sequence s_clear_held;
        (clear_act && !load_act) ##1 (clear_act && !load_act);
    endsequence

    sequence s_load_held;
        (load_act && !clear_act && !stor_edge) ##1 (load_act && !clear_act && !stor_edge);
    endsequence

    // ----------------------------------------------------------------
    // storage register checks
    // ----------------------------------------------------------------
    a_store_capture: assert property (stor_edge |=> store_q == $past(parallel_in_i))
        else $error("storage register missed capture");
    a_store_own_clk: assert property (!stor_edge |=> $stable(store_q))
        else $error("storage register changed without its clock");
    a_clear_store_kept: assert property (clear_act && !stor_edge |=> $stable(store_q))
        else $error("storage register disturbed by clear");

    // ----------------------------------------------------------------
    // load and clear checks
    // ----------------------------------------------------------------
    a_load_through: assert property (stor_edge && load_act && !clear_act |=> shift_q == $past(parallel_in_i))
        else $error("pins not passed through on load");
    a_async_copy: assert property (!stor_edge && load_act && !clear_act |=> shift_q == $past(store_q))
        else $error("storage not copied while load active");
    a_load_held: assert property (s_load_held |-> shift_q == store_q)
        else $error("shift register left storage while load held");
    a_clear_zero: assert property (clear_act && !load_act |=> shift_q == PSR_CLEARED)
        else $error("shift register not cleared");
    a_clear_held: assert property (s_clear_held |-> shift_q == PSR_CLEARED)
        else $error("shift register left zero while clear held");
    a_load_blocks_shift: assert property (load_act && !clear_act && !stor_edge && shift_edge |=>
        shift_q == $past(store_q))
        else $error("shift edge acted during load");
    a_clear_blocks_shift: assert property (clear_act && shift_edge |=> shift_q == PSR_CLEARED)
        else $error("shift edge acted during clear");

    // ----------------------------------------------------------------
    // shifting and serial output checks
    // ----------------------------------------------------------------
    a_shift_step: assert property (s_shift_req |=>
        shift_q == {$past(shift_q[PSR_WIDTH-2:0]), $past(ctrl_i.serial_in)})
        else $error("shift step wrong");
    a_shift_gated: assert property (s_run_mode ##0 !shift_edge |=> $stable(shift_q))
        else $error("shift register moved without shift edge");
    a_shift_pair: assert property (s_shift_pair |=> serial_out_o == $past(shift_q[PSR_WIDTH-3], 3))
        else $error("two shifts did not move data two stages");
    a_out_follows: assert property (s_run_mode ##0 shift_edge |=> serial_out_o == $past(shift_q[PSR_WIDTH-2]))
        else $error("serial out not stage seven after shift");

    // ----------------------------------------------------------------
    // shifted-out bit buffer checks
    // ----------------------------------------------------------------
    a_shift_fills_buffer: assert property (s_shift_req ##0 shift_ready_o |=> bit_valid_o)
        else $error("shifted bit not offered by buffer");
    a_first_bit_out: assert property (s_shift_req ##0 !bit_valid_o |=> bit_data_o == $past(serial_out_o))
        else $error("buffer head is not the bit shifted out");
endmodule // psr_top

// file: sim/psr_host.sv
/*
 * Host partner model: drives control levels, parallel data and the
 * consumer ready flag of the bit buffer at the falling clock edge.
 * Assumes the caller gives one call per clock cycle.
 */
`timescale 1ns/1ns

module psr_host
    import psr_pkg::*;
(
    input  wire logic                 clock_i,
    output psr_ctrl_type              ctrl_o,
    output logic [PSR_WIDTH-1:0]      parallel_o,
    output logic                      ready_o
);
    initial begin
        ctrl_o     = psr_ctrl_type'(5'h06);
        parallel_o = 8'h00;
        ready_o    = 1'b0;
    end

    task automatic drive(input psr_ctrl_type c, input logic [PSR_WIDTH-1:0] d, input logic rdy);
        @(negedge clock_i);
        // never both low: illegal for the host; the shift register would clear
        if (!c.parallel_load_n && !c.shift_clear_n) c.parallel_load_n = 1'b1;
        ctrl_o     = c;
        parallel_o = d;
        ready_o    = rdy;
    endtask
endmodule // psr_host

// file: sim/tb.sv
/*
 * Self-checking bench for psr_top with a queue-based reference model.
 * Assumes the host partner in psr_host.sv and the package constants.
 */
`timescale 1ns/1ns

module tb;
    import psr_pkg::*;
    logic                 clock_i, resetn_i;
    logic                 serial_out_o, shift_ready_o, bit_valid_o, bit_data_o, bit_ready_i;
    psr_ctrl_type         ctrl_i;
    logic [PSR_WIDTH-1:0] parallel_in_i, m_store, m_shift;
    logic                 m_st_q, m_sh_q, push_ok;
    logic                 m_q[$];
    int                   miscompares = 0;
    int                   n_tests = 0;

    psr_top u_dut (.clock_i(clock_i), .resetn_i(resetn_i), .ctrl_i(ctrl_i), .parallel_in_i(parallel_in_i),
        .serial_out_o(serial_out_o), .shift_ready_o(shift_ready_o), .bit_valid_o(bit_valid_o),
        .bit_data_o(bit_data_o), .bit_ready_i(bit_ready_i));
    psr_host u_host (.clock_i(clock_i), .ctrl_o(ctrl_i), .parallel_o(parallel_in_i), .ready_o(bit_ready_i));

    // ------------------------------------------------------------
    // reference model
    // ------------------------------------------------------------
    always @(posedge clock_i or negedge resetn_i) begin
        if (!resetn_i) begin
            m_store = PSR_STORE_RST;
            m_shift = PSR_SHIFT_RST;
            m_st_q  = 1'b0;
            m_sh_q  = 1'b0;
            m_q.delete();
        end else begin
            push_ok = m_q.size() < PSR_FIFO_DEPTH;
            if (m_q.size() > 0 && bit_ready_i) void'(m_q.pop_front());
            if (ctrl_i.storage_clock && !m_st_q) m_store = parallel_in_i;
            if (!ctrl_i.shift_clear_n) m_shift = PSR_CLEARED;
            else if (!ctrl_i.parallel_load_n) m_shift = m_store;
            else if (ctrl_i.shift_clock && !m_sh_q) begin
                if (push_ok) m_q.push_back(m_shift[7]);
                m_shift = {m_shift[6:0], ctrl_i.serial_in};
            end
            m_st_q = ctrl_i.storage_clock;
            m_sh_q = ctrl_i.shift_clock;
        end
    end

    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        n_tests++;
        if (seen !== exp) begin
            miscompares++;
            $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    // outputs are flops, so the falling edge sees them settled
    always @(negedge clock_i) begin
        if (resetn_i) begin
            check({7'h00, serial_out_o}, {7'h00, m_shift[7]});
            check({7'h00, shift_ready_o}, {7'h00, m_q.size() < PSR_FIFO_DEPTH});
            check({7'h00, bit_valid_o}, {7'h00, m_q.size() > 0});
            if (m_q.size() > 0) check({7'h00, bit_data_o}, {7'h00, m_q[0]});
        end
    end

    task automatic step(input logic [4:0] c, input logic [7:0] d, input logic r);
        u_host.drive(psr_ctrl_type'(c), d, r);
    endtask

    task automatic final_report();
        $display("comparisons %0d mismatches %0d", n_tests, miscompares);
        if (miscompares == 0 && n_tests > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask

    // ------------------------------------------------------------
    // stimulus
    // ------------------------------------------------------------
    initial begin
        clock_i = 1'b0;
        forever #10 clock_i = ~clock_i;
    end

    initial begin
        int i;
        resetn_i = 1'b0;
        void'($urandom(32'hba6a9e24));
        repeat (2) @(negedge clock_i);
        resetn_i <= 1'b1;
        // control code is {storage, shift, load_n, clear_n, serial_in}
        step(5'h12, 8'hA5, 1'b1);
        step(5'h06, 8'h3C, 1'b1);
        step(5'h0C, 8'h3C, 1'b1);
        step(5'h16, 8'h5A, 1'b1);
        step(5'h02, 8'hFF, 1'b1);
        for (i = 0; i < 16; i++) step({4'h7 >> (i % 2), 1'($urandom())}, 8'hFF, 1'b1);
        $display("test load_clear done");
        // stalled consumer: buffer fills, then drops bits
        for (i = 0; i < 12; i++) step({4'h7 >> (i % 2), 1'($urandom())}, 8'h00, 1'b0);
        i = 0;
        while (bit_valid_o !== 1'b0) begin
            step(5'h06, 8'h00, 1'b1);
            if (++i > 10) begin
                miscompares++;
                final_report();
            end
        end
        $display("test fifo_full done");
        for (i = 0; i < 600; i++) begin
            step(5'($urandom()), 8'($urandom()), 1'($urandom()));
            if (i == 300) begin
                @(negedge clock_i);
                resetn_i <= 1'b0;
                repeat (2) @(negedge clock_i);
                resetn_i <= 1'b1;
            end
        end
        $display("test random done");
        final_report();
    end
endmodule // tb
